// file: hw/sse_pkg.sv
// Shared constants and types for the skip and subtract execution block.
package sse_pkg;

  // Register byte offsets on the APB bus.
  localparam logic [7:0] REG_CMD    = 8'h00;
  localparam logic [7:0] REG_WORK   = 8'h04;
  localparam logic [7:0] REG_FLAGS  = 8'h08;
  localparam logic [7:0] REG_STATUS = 8'h0c;
  localparam logic [7:0] REG_MADDR  = 8'h10;
  localparam logic [7:0] REG_MDATA  = 8'h14;

  // Field positions inside the command and status registers.
  localparam int CMD_OP_LSB    = 0;
  localparam int CMD_ADDR_LSB  = 8;
  localparam int STAT_BUSY     = 0;
  localparam int STAT_SKIP     = 1;
  localparam int STAT_CYC_LSB  = 2;

  // Reset values.
  localparam logic [7:0] WORK_RESET = 8'h00;
  localparam logic [5:0] FLAG_RESET = 6'h00;

  // Instruction cycle counts.
  localparam logic [1:0] CYC_SINGLE = 2'h1;
  localparam logic [1:0] CYC_SKIP   = 2'h2;

  // Operations selected by a write to the command register; SSE_OP_NONE starts nothing.
  typedef enum logic [1:0] {
    SSE_OP_NONE,
    SSE_OP_SKIP,
    SSE_OP_SUBW,
    SSE_OP_MINUS_TO_MEMORY
  } sse_op_t;

  // Arithmetic status flags; bit 0 is the borrow-not flag.
  typedef struct packed {
    logic multiByteNil;
    logic signedBorrow;
    logic signedWrap;
    logic resultNil;
    logic halfBorrow;
    logic borrowNot;
  } sse_flags_t;

  // APB request and answer carriers.
  typedef struct packed {
    logic        psel;
    logic        penable;
    logic        pwrite;
    logic [7:0]  paddr;
    logic [31:0] pwdata;
  } sse_apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
  } sse_apb_rsp_t;

endpackage : sse_pkg

// file: hw/sse_sub_alu.sv
// Eight-bit subtractor producing the difference and all status flags.
`timescale 1ns/1ps
module sse_sub_alu (
  input  wire logic [7:0]          minuend,
  input  wire logic [7:0]          subtrahend,
  output logic [7:0]               diff,
  output sse_pkg::sse_flags_t      flags
);

  logic [8:0] wide;

  // Subtraction with borrow-not semantics: a set carry means no borrow.
  always_comb begin
    wide                = {1'b0, minuend} - {1'b0, subtrahend};
    diff                = wide[7:0];
    flags.borrowNot     = ~wide[8];
    flags.halfBorrow    = (minuend[3:0] >= subtrahend[3:0]);
    flags.resultNil     = (wide[7:0] == 8'h00);
    flags.signedWrap    = (minuend[7] ^ subtrahend[7]) & (minuend[7] ^ wide[7]);
    flags.signedBorrow  = flags.signedWrap ^ wide[7];
    flags.multiByteNil  = flags.resultNil;
  end

endmodule : sse_sub_alu

// file: hw/sse_data_mem.sv
// Small byte-wide data memory with asynchronous read and one write port.
`timescale 1ns/1ps
module sse_data_mem #(
  parameter int DEPTH  = 32,
  parameter int ADDR_W = 5
) (
  input  wire logic              mclk,
  input  wire logic              rst_n,
  input  wire logic              we,
  input  wire logic [ADDR_W-1:0] waddr,
  input  wire logic [7:0]        wdata,
  input  wire logic [ADDR_W-1:0] raddr,
  output logic [7:0]             rdata
);

  typedef struct packed {
    logic [DEPTH-1:0][7:0] bytes;
  } sse_mem_t;

  sse_mem_t s_r;
  sse_mem_t s_nxt;

  // Refuse a depth that the address cannot reach.
  if (DEPTH < 2 || DEPTH > (1 << ADDR_W)) begin : g_bad_depth
    $error("sse_data_mem: DEPTH does not fit ADDR_W");
  end

  // Read is combinational; an address past the end reads as zero.
  assign rdata = (int'(raddr) < DEPTH) ? s_r.bytes[raddr] : 8'h00;

  // One write per cycle.
  always_comb begin
    s_nxt = s_r;
    if (we && int'(waddr) < DEPTH) begin
      s_nxt.bytes[waddr] = wdata;
    end
  end

  // Memory contents clear at reset.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r <= '0;
    end else begin
      s_r <= s_nxt;
    end
  end

endmodule : sse_data_mem

// file: hw/sse_exec.sv
// Execution core for skip-if-nonzero and the two subtract forms, with APB registers.
//
// Added by the designer: the placing of the registers and the APB register port.
`timescale 1ns/1ps

module sse_exec #(
  parameter int MEM_DEPTH = 32,
  parameter int ADDR_W    = 5
) (
  input  wire logic                  mclk,
  input  wire logic                  rst_n,
  input  wire sse_pkg::sse_apb_req_t apbReq,
  output sse_pkg::sse_apb_rsp_t      apbRsp,
  output logic                       busy,
  output logic                       skipNext
);

  typedef enum logic [1:0] {
    ST_IDLE,
    ST_EXEC,
    ST_DUMMY
  } sse_state_t;

  typedef struct packed {
    sse_state_t          fsm;
    sse_pkg::sse_op_t    cmdOp;
    logic [ADDR_W-1:0]   cmdAddr;
    logic [ADDR_W-1:0]   mAddr;
    logic [7:0]          work;
    sse_pkg::sse_flags_t flags;
    logic [1:0]          cycles;
    logic                skipNext;
    logic                busy;
    logic [31:0]         prdata;
    logic                pready;
    logic                pslverr;
  } sse_core_t;

  sse_core_t           s_r;
  sse_core_t           s_nxt;
  logic                memWe;
  logic [ADDR_W-1:0]   memWaddr;
  logic [7:0]          memWdata;
  logic [ADDR_W-1:0]   memRaddr;
  logic [7:0]          memRdata;
  logic [7:0]          aluDiff;
  sse_pkg::sse_flags_t aluFlags;
  logic                access;
  logic                done;
  logic                hit;
  logic [31:0]         readMux;

  // Refuse address widths that do not fit the command field.
  if (ADDR_W < 1 || ADDR_W > 8) begin : g_bad_addr
    $error("sse_exec: ADDR_W must be 1 to 8");
  end

  sse_data_mem #(
    .DEPTH  (MEM_DEPTH),
    .ADDR_W (ADDR_W)
  ) u_mem (
    .mclk  (mclk),
    .rst_n (rst_n),
    .we    (memWe),
    .waddr (memWaddr),
    .wdata (memWdata),
    .raddr (memRaddr),
    .rdata (memRdata)
  );

  sse_sub_alu u_alu (
    .minuend    (s_r.work),
    .subtrahend (memRdata),
    .diff       (aluDiff),
    .flags      (aluFlags)
  );

  // Bus phase decode and register read mux.
  always_comb begin
    access  = apbReq.psel & apbReq.penable;
    done    = access & s_r.pready;
    hit     = 1'b1;
    readMux = 32'h0000_0000;
    unique case (apbReq.paddr)
      sse_pkg::REG_CMD:    readMux = {16'h0000, 8'(s_r.cmdAddr), 6'h00, s_r.cmdOp};
      sse_pkg::REG_WORK:   readMux = {24'h000000, s_r.work};
      sse_pkg::REG_FLAGS:  readMux = {26'h0000000, s_r.flags};
      sse_pkg::REG_STATUS: begin
        readMux[sse_pkg::STAT_BUSY] = s_r.busy;
        readMux[sse_pkg::STAT_SKIP] = s_r.skipNext;
        readMux[sse_pkg::STAT_CYC_LSB +: 2] = s_r.cycles;
      end
      sse_pkg::REG_MADDR:  readMux = {24'h000000, 8'(s_r.mAddr)};
      sse_pkg::REG_MDATA:  readMux = {24'h000000, memRdata};
      default:             hit = 1'b0;
    endcase
  end

  // Next state: bus writes, then instruction execution.
  always_comb begin
    s_nxt    = s_r;
    memWe    = 1'b0;
    memWaddr = s_r.cmdAddr;
    memWdata = 8'h00;
    memRaddr = (s_r.fsm == ST_IDLE) ? s_r.mAddr : s_r.cmdAddr;

    // One wait state: answer is prepared in the first access cycle.
    s_nxt.pready = access & ~s_r.pready;
    if (access && !s_r.pready) begin
      s_nxt.prdata  = hit ? readMux : 32'h0000_0000;
      s_nxt.pslverr = ~hit;
    end else if (done) begin
      s_nxt.pslverr = 1'b0;
    end

    // Writes take effect only at the completing edge; core state other than the memory address only while idle.
    if (done && apbReq.pwrite && hit) begin
      unique case (apbReq.paddr)
        sse_pkg::REG_CMD: begin
          if (s_r.fsm == ST_IDLE &&
              apbReq.pwdata[sse_pkg::CMD_OP_LSB +: 2] != 2'h0) begin
            s_nxt.cmdOp    = sse_pkg::sse_op_t'(apbReq.pwdata[sse_pkg::CMD_OP_LSB +: 2]);
            s_nxt.cmdAddr  = apbReq.pwdata[sse_pkg::CMD_ADDR_LSB +: ADDR_W];
            s_nxt.fsm      = ST_EXEC;
            s_nxt.skipNext = 1'b0;
          end
        end
        sse_pkg::REG_WORK: begin
          if (s_r.fsm == ST_IDLE) begin
            s_nxt.work = apbReq.pwdata[7:0];
          end
        end
        sse_pkg::REG_FLAGS: begin
          if (s_r.fsm == ST_IDLE) begin
            s_nxt.flags = apbReq.pwdata[5:0];
          end
        end
        sse_pkg::REG_MADDR: s_nxt.mAddr = apbReq.pwdata[ADDR_W-1:0];
        sse_pkg::REG_MDATA: begin
          if (s_r.fsm == ST_IDLE) begin
            memWe    = 1'b1;
            memWaddr = s_r.mAddr;
            memWdata = apbReq.pwdata[7:0];
          end
        end
        default: ;
      endcase
    end

    // Instruction sequencer.
    unique case (s_r.fsm)
      ST_IDLE: ;
      ST_EXEC: begin
        unique case (s_r.cmdOp)
          sse_pkg::SSE_OP_SKIP: begin
            memWe    = 1'b1;
            memWdata = memRdata;
            if (memRdata != 8'h00) begin
              s_nxt.fsm      = ST_DUMMY;
              s_nxt.skipNext = 1'b1;
              s_nxt.cycles   = sse_pkg::CYC_SKIP;
            end else begin
              s_nxt.fsm    = ST_IDLE;
              s_nxt.cycles = sse_pkg::CYC_SINGLE;
            end
          end
          sse_pkg::SSE_OP_SUBW: begin
            s_nxt.work   = aluDiff;
            s_nxt.flags  = aluFlags;
            s_nxt.fsm    = ST_IDLE;
            s_nxt.cycles = sse_pkg::CYC_SINGLE;
          end
          sse_pkg::SSE_OP_MINUS_TO_MEMORY: begin
            memWe        = 1'b1;
            memWdata     = aluDiff;
            s_nxt.flags  = aluFlags;
            s_nxt.fsm    = ST_IDLE;
            s_nxt.cycles = sse_pkg::CYC_SINGLE;
          end
          default: s_nxt.fsm = ST_IDLE;
        endcase
      end
      ST_DUMMY: s_nxt.fsm = ST_IDLE;
      default:  s_nxt.fsm = ST_IDLE;
    endcase

    s_nxt.busy = (s_nxt.fsm != ST_IDLE);
  end

  // State register.
  always_ff @(posedge mclk or negedge rst_n) begin
    if (!rst_n) begin
      s_r        <= '0;
      s_r.fsm    <= ST_IDLE;
      s_r.work   <= sse_pkg::WORK_RESET;
      s_r.flags  <= sse_pkg::FLAG_RESET;
    end else begin
      s_r <= s_nxt;
    end
  end

  // Outputs come straight from the state register.
  assign apbRsp.prdata  = s_r.prdata;
  assign apbRsp.pready  = s_r.pready;
  assign apbRsp.pslverr = s_r.pslverr;
  assign busy           = s_r.busy;
  assign skipNext       = s_r.skipNext;

  // Checks on the execution sequence and on the APB answer.
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_n);

  logic execSkip;
  logic execSubw;
  logic execSubm;
  assign execSkip = (s_r.fsm == ST_EXEC) && (s_r.cmdOp == sse_pkg::SSE_OP_SKIP);
  assign execSubw = (s_r.fsm == ST_EXEC) && (s_r.cmdOp == sse_pkg::SSE_OP_SUBW);
  assign execSubm = (s_r.fsm == ST_EXEC) && (s_r.cmdOp == sse_pkg::SSE_OP_MINUS_TO_MEMORY);

  a_skip_taken: assert property (
    execSkip && memRdata != 8'h00 |=> s_r.fsm == ST_DUMMY && skipNext ##1 s_r.fsm == ST_IDLE && busy == 1'b0)
    else $error("Taken skip did not insert exactly one dummy cycle.");

  a_skip_fallthru: assert property (
    execSkip && memRdata == 8'h00 |=> s_r.fsm == ST_IDLE && !skipNext && s_r.cycles == 2'h1)
    else $error("Skip on zero byte did not fall through.");

  a_skip_writeback: assert property (
    execSkip |-> memWe && memWdata == memRdata && memWaddr == s_r.cmdAddr)
    else $error("Skip did not write the byte back unchanged.");

  a_skip_flags: assert property (
    execSkip |=> $stable(s_r.flags)[*2])
    else $error("Skip altered the status flags.");

  a_subw_result: assert property (
    execSubw |=> s_r.work == $past(aluDiff) && $stable(u_mem.s_r))
    else $error("Subtract to working register gave a wrong result.");

  a_borrow_flag: assert property (
    execSubw || execSubm |=> s_r.flags.borrowNot == ($past(s_r.work) >= $past(memRdata)))
    else $error("Borrow-not flag wrong after subtraction.");

  a_subw_flags: assert property (
    execSubw |=> s_r.flags.resultNil == (s_r.work == 8'h00) && s_r.flags == $past(aluFlags))
    else $error("Subtract to working register left flags wrong.");

  a_minus_to_memory_store: assert property (
    execSubm |-> memWe && memWaddr == s_r.cmdAddr && memWdata == s_r.work - memRdata ##1 $stable(s_r.work))
    else $error("Subtract to memory did not store the difference.");

  a_apb_wait: assert property (
    access && !apbRsp.pready |=> apbRsp.pready ##1 !apbRsp.pready)
    else $error("Bus answer was not one wait state.");

  a_slverr_unmapped: assert property (
    access && !s_r.pready && !hit |=> apbRsp.pslverr && apbRsp.prdata == 32'h0000_0000)
    else $error("Unmapped address was not refused.");

  a_prdata_hold: assert property (
    !(access && !s_r.pready) |=> $stable(apbRsp.prdata))
    else $error("Read data changed outside answer preparation.");

  a_write_at_done: assert property (
    access && !s_r.pready |=> $stable(s_r.work) && $stable(s_r.mAddr) && $stable(s_r.flags))
    else $error("Register changed before the completing edge.");

  a_cmd_zero_op: assert property (
    done && apbReq.pwrite && apbReq.paddr == sse_pkg::REG_CMD &&
    apbReq.pwdata[sse_pkg::CMD_OP_LSB +: 2] == 2'h0 |=> !busy && $stable(s_r.cmdOp))
    else $error("Command with an empty operation started work.");

  a_cmd_start: assert property (
    done && apbReq.pwrite && apbReq.paddr == sse_pkg::REG_CMD &&
    apbReq.pwdata[sse_pkg::CMD_OP_LSB +: 2] != 2'h0 && !busy
    |=> busy && !skipNext && s_r.fsm == ST_EXEC)
    else $error("Command did not start an instruction.");

  a_minus_to_memory_flags: assert property (
    execSubm |=> s_r.flags.resultNil == ($past(s_r.work) == $past(memRdata)) &&
                 s_r.flags.halfBorrow == ($past(s_r.work[3:0]) >= $past(memRdata[3:0])))
    else $error("Subtract to memory left flags wrong.");

  a_skip_memhold: assert property (
    execSkip |=> $stable(u_mem.s_r))
    else $error("Skip changed the data memory.");

  a_flags_hold: assert property (
    !execSubw && !execSubm && !(done && apbReq.pwrite && apbReq.paddr == sse_pkg::REG_FLAGS)
    |=> $stable(s_r.flags))
    else $error("Status flags changed without a subtraction or a write.");

  a_sub_single: assert property (
    execSubw || execSubm |=> s_r.fsm == ST_IDLE && s_r.cycles == 2'h1 && !skipNext && !busy)
    else $error("Subtraction did not finish in one cycle.");

  a_skip_work: assert property (
    execSkip |=> $stable(s_r.work))
    else $error("Skip changed the working register.");

endmodule : sse_exec

// file: sim/tb_skip_subtract_exec.sv
// Self-checking testbench for the skip and subtract execution block.
`timescale 1ns/1ps
module tb_skip_subtract_exec;
  logic                  mclk;
  logic                  rst_n;
  sse_pkg::sse_apb_req_t apbReq;
  sse_pkg::sse_apb_rsp_t apbRsp;
  logic                  busy;
  logic                  skipNext;
  int                    failures;
  int                    totalChecks;

  sse_exec #(.MEM_DEPTH(32), .ADDR_W(5)) u_sse_exec (
    .mclk     (mclk),
    .rst_n    (rst_n),
    .apbReq   (apbReq),
    .apbRsp   (apbRsp),
    .busy     (busy),
    .skipNext (skipNext)
  );

  // Free-running 100 MHz clock.
  initial begin
    mclk = 1'b0;
    forever #5 mclk = ~mclk;
  end

  // Prints the verdict and ends the run.
  task automatic conclude();
    if (failures == 0 && totalChecks > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask : conclude

  // Compares one value and reports a mismatch at once.
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    totalChecks++;
    if (got !== exp) begin
      failures++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : chk

  // One APB transfer; the request is held until pready is sampled high.
  task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                      output logic [31:0] rd, output logic err);
    int n;
    n = 0;
    apbReq <= '{psel: 1'b1, penable: 1'b0, pwrite: wr, paddr: a, pwdata: wd};
    @(posedge mclk);
    apbReq.penable <= 1'b1;
    do begin
      @(posedge mclk);
      n++;
    end while (apbRsp.pready !== 1'b1 && n < 20);
    if (n >= 20) failures++;
    rd = apbRsp.prdata;
    err = apbRsp.pslverr;
    apbReq.psel <= 1'b0;
    apbReq.penable <= 1'b0;
    @(posedge mclk);
  endtask : xfer

  // Register write and read shorthands.
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    logic        e;
    xfer(1'b1, a, d, r, e);
  endtask : wr

  task automatic rdChk(input logic [7:0] a, input logic [31:0] exp);
    logic [31:0] r;
    logic        e;
    xfer(1'b0, a, 32'h0, r, e);
    chk(r, exp);
  endtask : rdChk

  // Starts an instruction and polls the status until it is idle again.
  task automatic exec(input logic [1:0] op, input logic [4:0] addr, output logic [31:0] st);
    logic e;
    int   n;
    wr(sse_pkg::REG_CMD, (32'(addr) << sse_pkg::CMD_ADDR_LSB) | 32'(op));
    chk(32'(busy), 32'h1);
    n = 0;
    do begin
      xfer(1'b0, sse_pkg::REG_STATUS, 32'h0, st, e);
      n++;
    end while (st[sse_pkg::STAT_BUSY] !== 1'b0 && n < 10);
    if (n >= 10) failures++;
    chk(32'(busy), 32'h0);
  endtask : exec

  // Expected flags of work minus mem.
  function automatic logic [31:0] subFlags(input logic [7:0] w, input logic [7:0] m);
    sse_pkg::sse_flags_t f;
    logic [7:0]          d;
    d = w - m;
    f.borrowNot    = (w >= m);
    f.halfBorrow   = (w[3:0] >= m[3:0]);
    f.resultNil    = (d == 8'h00);
    f.signedWrap   = (w[7] != m[7]) && (d[7] != w[7]);
    f.signedBorrow = f.signedWrap ^ d[7];
    f.multiByteNil = f.resultNil;
    return 32'(f);
  endfunction : subFlags

  // Reset values and an unmapped address.
  task automatic testReset();
    logic [31:0] r;
    logic        e;
    rdChk(sse_pkg::REG_WORK, 32'h0);
    rdChk(sse_pkg::REG_FLAGS, 32'h0);
    rdChk(sse_pkg::REG_MADDR, 32'h0);
    wr(sse_pkg::REG_CMD, 32'h0000_0300);
    rdChk(sse_pkg::REG_CMD, 32'h0);
    chk(32'(busy), 32'h0);
    rdChk(sse_pkg::REG_STATUS, 32'h0);
    xfer(1'b0, 8'h18, 32'h0, r, e);
    chk({r[30:0], e}, 32'h1);
  endtask : testReset

  // Skip with a nonzero byte, then with a zero byte.
  task automatic testSkip();
    logic [31:0] st;
    wr(sse_pkg::REG_MADDR, 32'h3);
    wr(sse_pkg::REG_MDATA, 32'h5a);
    wr(sse_pkg::REG_FLAGS, 32'h2a);
    exec(2'h1, 5'h3, st);
    chk(st & 32'hf, 32'ha);
    chk(32'(skipNext), 32'h1);
    rdChk(sse_pkg::REG_FLAGS, 32'h2a);
    rdChk(sse_pkg::REG_MDATA, 32'h5a);
    exec(2'h1, 5'h4, st);
    chk(st & 32'hf, 32'h4);
    chk(32'(skipNext), 32'h0);
    rdChk(sse_pkg::REG_FLAGS, 32'h2a);
  endtask : testSkip

  // Subtract into the working register over sign and zero corners.
  task automatic testSubWork();
    logic [7:0]  wv [6] = '{8'h50, 8'h20, 8'h33, 8'h80, 8'h7f, 8'h05};
    logic [7:0]  mv [6] = '{8'h30, 8'h50, 8'h33, 8'h01, 8'hff, 8'h06};
    logic [31:0] st;
    for (int i = 0; i < 6; i++) begin
      wr(sse_pkg::REG_WORK, 32'(wv[i]));
      wr(sse_pkg::REG_MADDR, 32'h5);
      wr(sse_pkg::REG_MDATA, 32'(mv[i]));
      exec(2'h2, 5'h5, st);
      rdChk(sse_pkg::REG_WORK, 32'(8'(wv[i] - mv[i])));
      rdChk(sse_pkg::REG_FLAGS, subFlags(wv[i], mv[i]));
      rdChk(sse_pkg::REG_MDATA, 32'(mv[i]));
    end
  endtask : testSubWork

  // Subtract with the result written back to memory.
  task automatic testSubMem();
    logic [31:0] st;
    wr(sse_pkg::REG_WORK, 32'h10);
    wr(sse_pkg::REG_MADDR, 32'h6);
    wr(sse_pkg::REG_MDATA, 32'h20);
    exec(2'h3, 5'h6, st);
    rdChk(sse_pkg::REG_MDATA, 32'hf0);
    rdChk(sse_pkg::REG_WORK, 32'h10);
    rdChk(sse_pkg::REG_CMD, 32'h0000_0603);
    rdChk(sse_pkg::REG_FLAGS, subFlags(8'h10, 8'h20));
  endtask : testSubMem

  // Main sequence: reset for two cycles, then every scenario.
  initial begin
    rst_n = 1'b0;
    apbReq = '0;
    failures = 0;
    totalChecks = 0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    testReset();
    testSkip();
    testSubWork();
    testSubMem();
    // A second reset in mid-run must bring every register back.
    rst_n <= 1'b0;
    repeat (2) @(posedge mclk);
    rst_n <= 1'b1;
    @(posedge mclk);
    testReset();
    conclude();
  end

  // Watchdog against a hung handshake.
  initial begin
    #100us;
    failures++;
    conclude();
  end
endmodule : tb_skip_subtract_exec
